// ### design/itc_pkg.sv
// Constants and types for the interval timer control-word decoder
package itc_pkg;
  localparam logic [7:0] PORT_CNT0 = 8'h40;
  localparam logic [7:0] PORT_CTRL = 8'h43;
  localparam int NUM_CNT = 3;
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_RW_HI = 5;
  localparam int CW_RW_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;
  localparam int RB_LATCH_CNT = 5;
  localparam int RB_LATCH_STAT = 4;
  localparam int RB_SEL0 = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [15:0] MAX_BIN_COUNT = 16'h0000;
  localparam logic [15:0] MAX_BCD_COUNT = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [2:0] {
    ITC_MODE_TC_OUT = 3'h0,
    ITC_MODE_ONESHOT = 3'h1,
    ITC_MODE_RATE = 3'h2,
    ITC_MODE_SQUARE = 3'h3,
    ITC_MODE_SW_STROBE = 3'h4,
    ITC_MODE_HW_STROBE = 3'h5
  } itc_mode_t;

  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode_raw;
    logic bcd;
  } itc_ctrl_t;

  typedef struct packed {
    itc_ctrl_t ctrl;
    itc_mode_t mode;
  } itc_cfg_t;
endpackage

// ### design/itc_control_decode.sv
// Control word decode, count latch, read-back and port read sequencing for three counters
module itc_control_decode #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  input wire logic [itc_pkg::NUM_CNT-1:0][CNT_W-1:0] ce_count_in,
  input wire logic [itc_pkg::NUM_CNT-1:0] ce_out_in,
  input wire logic [itc_pkg::NUM_CNT-1:0] ce_loaded_in,
  output itc_pkg::itc_cfg_t [itc_pkg::NUM_CNT-1:0] cfg_out,
  output logic [itc_pkg::NUM_CNT-1:0][CNT_W-1:0] count_holding_register_out,
  output logic [itc_pkg::NUM_CNT-1:0] cr_load_out,
  output logic [itc_pkg::NUM_CNT-1:0] counter_out_out
);
  logic rst_sync1_reg;
  logic rst_n_reg;
  logic cw_wr;
  logic is_readback;
  logic [itc_pkg::NUM_CNT-1:0] port_wr;
  logic [itc_pkg::NUM_CNT-1:0] port_rd;
  logic [itc_pkg::NUM_CNT-1:0][7:0] rd_byte;
  logic [7:0] rdata_next;

  // Reset released through two flops so every flop leaves reset on the same edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg <= rst_sync1_reg;
    end
  end

  assign cw_wr = io_wr_in && (io_addr_in == itc_pkg::PORT_CTRL);
  assign is_readback = io_wdata_in[itc_pkg::CW_SEL_HI:itc_pkg::CW_SEL_LO] == itc_pkg::SEL_READBACK;

  // Mode field with don't-care top bit for modes 2 and 3
  function automatic itc_pkg::itc_mode_t mode_decode(input logic [2:0] raw);
    itc_pkg::itc_mode_t m;
    m = itc_pkg::ITC_MODE_TC_OUT;
    case (raw)
      3'h0: m = itc_pkg::ITC_MODE_TC_OUT;
      3'h1: m = itc_pkg::ITC_MODE_ONESHOT;
      3'h2, 3'h6: m = itc_pkg::ITC_MODE_RATE;
      3'h3, 3'h7: m = itc_pkg::ITC_MODE_SQUARE;
      3'h4: m = itc_pkg::ITC_MODE_SW_STROBE;
      3'h5: m = itc_pkg::ITC_MODE_HW_STROBE;
      default: m = itc_pkg::ITC_MODE_TC_OUT;
    endcase
    return m;
  endfunction

  genvar i;
  generate
    for (i = 0; i < itc_pkg::NUM_CNT; i++)
    begin : g_cnt
      logic sel_hit;
      logic rb_hit;
      logic prog_wr;
      logic cnt_latch_req;
      logic stat_latch_req;
      logic cr_done;
      itc_pkg::itc_ctrl_t ctrl_reg;
      logic [CNT_W-1:0] cr_reg;
      logic [CNT_W-1:0] latch_val_reg;
      logic latch_full_reg;
      logic [7:0] status_reg;
      logic status_full_reg;
      logic null_reg;
      logic out_reg;
      logic wr_msb_reg;
      logic rd_msb_reg;
      logic load_pulse_reg;
      logic use_msb;

      assign port_wr[i] = io_wr_in && (io_addr_in == itc_pkg::PORT_CNT0 + 8'(i));
      assign port_rd[i] = io_rd_in && (io_addr_in == itc_pkg::PORT_CNT0 + 8'(i));
      assign sel_hit = io_wdata_in[itc_pkg::CW_SEL_HI:itc_pkg::CW_SEL_LO] == 2'(i);
      assign rb_hit = cw_wr && is_readback && io_wdata_in[itc_pkg::RB_SEL0 + i];
      assign prog_wr = cw_wr && sel_hit
        && (io_wdata_in[itc_pkg::CW_RW_HI:itc_pkg::CW_RW_LO] != itc_pkg::RW_LATCH);
      // Bit high latches, taken from the field descriptions for both bits
      assign cnt_latch_req = (cw_wr && sel_hit
        && io_wdata_in[itc_pkg::CW_RW_HI:itc_pkg::CW_RW_LO] == itc_pkg::RW_LATCH)
        || (rb_hit && io_wdata_in[itc_pkg::RB_LATCH_CNT]);
      assign stat_latch_req = rb_hit && io_wdata_in[itc_pkg::RB_LATCH_STAT];
      assign cr_done = port_wr[i] && ((ctrl_reg.rw != itc_pkg::RW_BOTH) || wr_msb_reg);
      assign use_msb = (ctrl_reg.rw == itc_pkg::RW_MSB) || ((ctrl_reg.rw == itc_pkg::RW_BOTH) && rd_msb_reg);

      // Control word per counter; undefined after reset, zero here for determinism
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          ctrl_reg <= '0;
        else if (prog_wr)
          ctrl_reg <= itc_pkg::itc_ctrl_t'({io_wdata_in[itc_pkg::CW_RW_HI:itc_pkg::CW_RW_LO],
            io_wdata_in[itc_pkg::CW_MODE_HI:itc_pkg::CW_MODE_LO], io_wdata_in[itc_pkg::CW_BCD]});
      end

      // Count holding register written through the data port in programmed byte order
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          cr_reg <= '0;
          wr_msb_reg <= 1'b0;
          load_pulse_reg <= 1'b0;
        end
        else
        begin
          load_pulse_reg <= cr_done;
          if (prog_wr)
            wr_msb_reg <= 1'b0;
          else if (port_wr[i])
          begin
            case (ctrl_reg.rw)
              itc_pkg::RW_MSB: cr_reg <= CNT_W'({io_wdata_in, 8'h00});
              itc_pkg::RW_BOTH:
              begin
                if (wr_msb_reg)
                  cr_reg[CNT_W-1:8] <= io_wdata_in[CNT_W-9:0];
                else
                  cr_reg <= CNT_W'(io_wdata_in);
                wr_msb_reg <= !wr_msb_reg;
              end
              default: cr_reg <= CNT_W'(io_wdata_in);
            endcase
          end
        end
      end

      // Null flag: set by programming or a fresh count, cleared when the counter takes it
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          null_reg <= 1'b0;
        else if (prog_wr || cr_done)
          null_reg <= 1'b1;
        else if (ce_loaded_in[i])
          null_reg <= 1'b0;
      end

      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          out_reg <= 1'b0;
        else
          out_reg <= ce_out_in[i];
      end

      // Count latch; a pending latch blocks further latches until fully read or the counter is reprogrammed
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          latch_val_reg <= '0;
          latch_full_reg <= 1'b0;
        end
        else if (prog_wr)
          latch_full_reg <= 1'b0;
        else if (cnt_latch_req && !latch_full_reg)
        begin
          latch_val_reg <= ce_count_in[i];
          latch_full_reg <= 1'b1;
        end
        else if (port_rd[i] && !status_full_reg && latch_full_reg
          && ((ctrl_reg.rw != itc_pkg::RW_BOTH) || rd_msb_reg))
          latch_full_reg <= 1'b0;
      end

      // Status latch, read once before any latched count
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          status_reg <= itc_pkg::STATUS_RESET;
          status_full_reg <= 1'b0;
        end
        else if (prog_wr)
          status_full_reg <= 1'b0;
        else if (stat_latch_req && !status_full_reg)
        begin
          status_reg <= {out_reg, null_reg, ctrl_reg.rw, ctrl_reg.mode_raw, ctrl_reg.bcd};
          status_full_reg <= 1'b1;
        end
        else if (port_rd[i])
          status_full_reg <= 1'b0;
      end

      // Byte pointer for two-byte reads; only this counter's own reads and its programming move it
      always_ff @(posedge clk_sys_in or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          rd_msb_reg <= 1'b0;
        else if (prog_wr)
          rd_msb_reg <= 1'b0;
        else if (port_rd[i] && !status_full_reg && (ctrl_reg.rw == itc_pkg::RW_BOTH))
          rd_msb_reg <= !rd_msb_reg;
      end

      // Status first, then latched count, else the live count
      always_comb
      begin
        if (status_full_reg)
          rd_byte[i] = status_reg;
        else if (latch_full_reg)
          rd_byte[i] = use_msb ? latch_val_reg[CNT_W-1:8] : latch_val_reg[7:0];
        else
          rd_byte[i] = use_msb ? ce_count_in[i][CNT_W-1:8] : ce_count_in[i][7:0];
      end

      assign cfg_out[i] = {ctrl_reg, mode_decode(ctrl_reg.mode_raw)};
      assign count_holding_register_out[i] = cr_reg;
      assign cr_load_out[i] = load_pulse_reg;
      assign counter_out_out[i] = out_reg;
    end
  endgenerate

  always_comb
  begin
    rdata_next = itc_pkg::UNMAPPED_READ;
    for (int k = 0; k < itc_pkg::NUM_CNT; k++)
    begin
      if (port_rd[k])
        rdata_next = rd_byte[k];
    end
  end

  // Read data held in a flop; the control port is write-only and reads as zero
  always_ff @(posedge clk_sys_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      io_rdata_out <= 8'h00;
      io_rvalid_out <= 1'b0;
    end
    else
    begin
      io_rvalid_out <= io_rd_in;
      if (io_rd_in)
        io_rdata_out <= rdata_next;
    end
  end
endmodule

// ### test/itc_checker.sv
// Port assertions for the timer control decoder
module itc_checker (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_rvalid_out,
  input wire logic [itc_pkg::NUM_CNT-1:0] ce_out_in,
  input wire itc_pkg::itc_cfg_t [itc_pkg::NUM_CNT-1:0] cfg_out,
  input wire logic [itc_pkg::NUM_CNT-1:0] cr_load_out,
  input wire logic [itc_pkg::NUM_CNT-1:0] counter_out_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  wire logic cw = io_wr_in && io_addr_in == itc_pkg::PORT_CTRL;
  wire logic [1:0] sel = io_wdata_in[7:6];
  wire logic [1:0] rw = io_wdata_in[5:4];
  property p_rd_ans; io_rd_in |=> io_rvalid_out; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_rd_quiet; !io_rd_in |=> !io_rvalid_out; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read answer");
  property p_unmapped; io_rd_in && io_addr_in >= itc_pkg::PORT_CTRL |=> io_rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_prog; cw && sel == 2'h1 && rw != 2'h0 |=> cfg_out[1].ctrl == $past(io_wdata_in[5:0]); endproperty
  a_prog: assert property (p_prog) else $error("control word not stored");
  property p_mode; cfg_out[1].ctrl.mode_raw[1] |-> cfg_out[1].mode == {1'b0, cfg_out[1].ctrl.mode_raw[1:0]}; endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_latch_keep; cw && rw == 2'h0 && sel != 2'h3 |=> $stable(cfg_out); endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed config");
  property p_rb_keep; cw && sel == 2'h3 |=> $stable(cfg_out); endproperty
  a_rb_keep: assert property (p_rb_keep) else $error("read-back changed config");
  property p_out; $stable(ce_out_in) |-> counter_out_out == ce_out_in; endproperty
  a_out: assert property (p_out) else $error("output level lost");
  property p_load; |cr_load_out |-> $past(io_wr_in) && $past(io_addr_in) < 8'h43; endproperty
  a_load: assert property (p_load) else $error("load without count write");
endmodule

bind itc_control_decode itc_checker u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
  .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out), .ce_out_in(ce_out_in),
  .cfg_out(cfg_out), .cr_load_out(cr_load_out), .counter_out_out(counter_out_out));

// ### test/itc_ce_model.sv
// Counting element model for the three counters
module itc_ce_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic [2:0] load_in,
  input wire logic [2:0][15:0] hold_in,
  output logic [2:0][15:0] count_out,
  output logic [2:0] out_out,
  output logic [2:0] loaded_out
);
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      count_out <= '0;
      loaded_out <= '0;
    end
    else
    begin
      loaded_out <= load_in;
      for (int i = 0; i < 3; i++)
        if (load_in[i])
          count_out[i] <= hold_in[i];
        else if (run_in)
          count_out[i] <= count_out[i] - 16'h0001;
    end
  end
  // Pin level tied to count bit 0 so a latched status is predictable
  assign out_out = {count_out[2][0], count_out[1][0], count_out[0][0]};
endmodule

// ### test/interval_timer_control_decode_tb_top.sv
// Self-checking bench for the timer control decoder
module interval_timer_control_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] io_addr_in = 8'h00;
  logic io_wr_in = 1'b0;
  logic io_rd_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00;
  logic run = 1'b0;
  logic [7:0] io_rdata_out;
  logic io_rvalid_out;
  logic [2:0][15:0] ce_count, hold;
  logic [2:0] ce_out, ce_loaded, cr_load, counter_out_out;
  itc_pkg::itc_cfg_t [2:0] cfg_out;
  int err_count = 0;
  int n_checks = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  itc_control_decode dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .io_rvalid_out(io_rvalid_out), .ce_count_in(ce_count), .ce_out_in(ce_out), .ce_loaded_in(ce_loaded),
    .cfg_out(cfg_out), .count_holding_register_out(hold), .cr_load_out(cr_load),
    .counter_out_out(counter_out_out));
  itc_ce_model ce (.clk_in(clk_sys_in), .arst_n_in(arst_n_in), .run_in(run), .load_in(cr_load),
    .hold_in(hold), .count_out(ce_count), .out_out(ce_out), .loaded_out(ce_loaded));
  task automatic test_done();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(negedge clk_sys_in);
    io_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    io_addr_in = a;
    io_rd_in = 1'b1;
    @(negedge clk_sys_in);
    io_rd_in = 1'b0;
    chk({15'h0000, io_rvalid_out}, 16'h0001);
    chk({8'h00, io_rdata_out}, {8'h00, exp});
  endtask
  // Bounded wait for the counting element to take a written count
  task automatic wait_cnt(input int i, input logic [15:0] v);
    for (int k = 0; k < 8 && ce_count[i] !== v; k++)
      @(negedge clk_sys_in);
    chk(ce_count[i], v);
    if (ce_count[i] !== v)
      test_done();
  endtask
  initial
  begin
    repeat (10) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk({13'h0000, counter_out_out}, 16'h0000);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h43, {4'h5, m[2:0], 1'b1});
      chk({13'h0000, cfg_out[1].mode}, {13'h0000, (m[1] ? {1'b0, m[1:0]} : m[2:0])});
      chk({15'h0000, cfg_out[1].ctrl.bcd}, 16'h0001);
    end
    wr(8'h43, 8'h36);
    chk({15'h0000, cfg_out[0].ctrl.bcd}, 16'h0000);
    wr(8'h40, 8'h34);
    wr(8'h40, 8'h12);
    wait_cnt(0, 16'h1234);
    wr(8'h43, 8'h00);
    run = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    run = 1'b0;
    wr(8'h43, 8'h00);
    rd(8'h40, 8'h34);
    rd(8'h44, 8'h00);
    wr(8'h43, 8'hB4);
    rd(8'h40, 8'h12);
    // Latch freed after two bytes, so a new latch sees the moved count
    wr(8'h43, 8'h00);
    rd(8'h40, 8'h2F);
    rd(8'h40, 8'h12);
    wr(8'h42, 8'h05);
    wr(8'h42, 8'h00);
    wait_cnt(2, 16'h0005);
    wr(8'h43, 8'hFA);
    rd(8'h40, 8'hB6);
    rd(8'h42, 8'hB4);
    rd(8'h40, 8'h2F);
    rd(8'h42, 8'h05);
    rd(8'h40, 8'h12);
    rd(8'h42, 8'h00);
    wr(8'h43, 8'h50);
    wr(8'h43, 8'hD4);
    // Counter 1 was never loaded, so the run left it at FFFBh and its pin level high
    rd(8'h41, 8'hD0);
    wr(8'h43, 8'hE8);
    rd(8'h42, 8'h05);
    rd(8'h42, 8'h00);
    // MSB-only format: one byte written, one byte latched and read
    wr(8'h43, 8'h60);
    wr(8'h41, 8'h07);
    wait_cnt(1, 16'h0700);
    wr(8'h43, 8'h40);
    rd(8'h41, 8'h07);
    rd(8'h41, 8'h07);
    rd(8'h43, 8'h00);
    test_done();
  end
endmodule
